/* rtl/clock_ctrl_cfg.svh */
`ifndef CLOCK_CTRL_CFG_SVH
`define CLOCK_CTRL_CFG_SVH

// clock and timing figures
`define CLK_PERIOD_NS     10
`define TUNE_SETTLE_NS    1000000
`define WAKE_SETTLE_NS    200
`define SLOW_TUNE_EDGES   3'h7
`define FAST_HALF_CYC     40
`define SLOW_HALF_CYC     10000

// register offsets
`define ADDR_OSC_CONTROL  2'h0
`define ADDR_OSC_TUNING   2'h1
`define ADDR_OSC_CONFIG   2'h2
`define ADDR_OSC_AUX      2'h3

// reset values
`define RST_INTERNAL_FREQ_SELECT          3'h4
`define RST_FOSC          4'h8

// field positions
`define CTL_IDLE_BIT      7
`define CTL_RDY_BIT       3
`define TUN_LFSS_BIT      7
`define TUN_MULT_BIT      6
`define AUX_SECEN_BIT     0

// primary oscillator configuration codes
`define FOSC_ALL_IO       4'h8
`define FOSC_CLKOUT       4'h9

// synchroniser bit positions
`define SYN_PRI           0
`define SYN_SEC           1
`define SYN_SEC_START     2
`define SYN_PIN1          3
`define SYN_PIN2          4

`endif

/* rtl/clock_ctrl_pkg.sv */
package clock_ctrl_pkg;

    // power management state of the core
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_IDLE  = 2'b01,
        ST_SLEEP = 2'b10,
        ST_WAKE  = 2'b11
    } pwr_state_e;

    // device clock sources
    typedef enum logic [1:0] {
        SRC_FAST = 2'b00,
        SRC_SLOW = 2'b01,
        SRC_PRI  = 2'b10,
        SRC_SEC  = 2'b11
    } clk_src_e;

endpackage

/* rtl/internal_osc_and_idle_clock_ctrl.sv */
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "clock_ctrl_cfg.svh"
// How it works
// [RQ1] fast oscillator gives 8 MHz directly and postscaled 31 kHz to 4 MHz
// [RQ2] fast oscillator runs whenever a 125 kHz to 8 MHz setting is chosen
// [RQ3] slow rc runs when selected or any of four monitor features enabled
// [RQ4] frequency select picks fast direct, slow direct or a postscaled output
// [RQ5] clock-out mode: pin two gives device clock over four, pin one is port bit
// [RQ6] all-io mode: both oscillator pins become port bits seven and six
// [RQ7] slow rc has its own divider, independent of fast oscillator tuning
// [RQ8] tuning write: fast settles within 1 ms, slow within 8 cycles
// [RQ9] execution continues while tuning shifts; no completion flag exists
// [RQ10] at 31 kHz the low-frequency source bit chooses which oscillator
// [RQ11] multiplier gives four times the fast clock, enabled by tuning bit 6
// [RQ12] multiplier works only for internal primary and top two frequencies
// [RQ13] where multiplier unavailable its enable reads zero and does nothing
// [RQ14] software sets idle enable and clears clock select before sleep
// [RQ15] primary idle: cpu stopped, peripherals clocked, ready flag stays set
// [RQ16] wake from primary idle resumes cpu after settle, bits untouched
// [RQ17] software sets idle enable, writes 01 to clock select, then sleeps
// [RQ18] switching to secondary stops primary, clears ready, sets running flag
// [RQ19] wake from secondary idle resumes cpu after settle on secondary clock
// [RQ20] sleep ignored for secondary idle when secondary enable is clear
// [RQ21] peripheral clocks held off until the secondary oscillator starts
// [RQ22] every clock switch is free of glitches and truncated pulses
module internal_osc_and_idle_clock_ctrl #(
    parameter int FAST_HALF_CYC   = `FAST_HALF_CYC,
    parameter int SLOW_HALF_CYC   = `SLOW_HALF_CYC,
    parameter int TUNE_SETTLE_CYC = `TUNE_SETTLE_NS / `CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // register port
    input  wire logic [1:0]                reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [7:0]                reg_rdata_r,
    // core events
    input  wire logic                      sleep_instr,
    input  wire logic                      wake_event,
    // oscillator inputs from pins
    input  wire logic                      pri_osc_in,
    input  wire logic                      sec_osc_in,
    input  wire logic                      sec_osc_started,
    // oscillator pins
    input  wire logic                      osc_pin_one_in,
    output logic                           osc_pin_one_out_r,
    output logic                           osc_pin_one_oe_r,
    input  wire logic                      osc_pin_two_in,
    output logic                           osc_pin_two_out_r,
    output logic                           osc_pin_two_oe_r,
    // port a side of the shared pins
    input  wire logic                      port_a_bit_seven_out,
    input  wire logic                      port_a_bit_seven_oe,
    output logic                           port_a_bit_seven_in_r,
    input  wire logic                      port_a_bit_six_out,
    input  wire logic                      port_a_bit_six_oe,
    output logic                           port_a_bit_six_in_r,
    // clock outputs and status
    output logic                           dev_clk_r,
    output logic                           cpu_clk_on_r,
    output logic                           periph_clk_on_r,
    output logic                           fast_osc_on_r,
    output logic                           slow_rc_on_r,
    output logic                           pri_osc_en_r,
    output logic                           mult_active_r,
    output clock_ctrl_pkg::pwr_state_e     pwr_state_r
);
    import clock_ctrl_pkg::*;

    localparam logic [15:0] FAST_BASE  = 16'(FAST_HALF_CYC);
    localparam logic [15:0] SLOW_BASE  = 16'(SLOW_HALF_CYC);
    localparam int          STEP_CYC   = (TUNE_SETTLE_CYC / 64 > 1) ? TUNE_SETTLE_CYC / 64 : 1;
    localparam logic [23:0] STEP_LAST  = 24'(STEP_CYC - 1);
    localparam int          WAKE_CYC   = (`WAKE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam logic [15:0] WAKE_LAST  = 16'(WAKE_CYC - 1);

    // internal oscillator primary configurations
    function automatic logic fosc_internal(input logic [3:0] f);
        return (f == `FOSC_ALL_IO) || (f == `FOSC_CLKOUT);
    endfunction

    // half period of the fast path in reference clocks
    function automatic logic [15:0] fast_half(input logic [2:0] f, input logic m,
                                              input logic [15:0] b);
        logic [15:0] h;
        h = (f == 3'h0) ? (b << 8) : (b << (3'h7 - f));
        if (m) begin
            h = h >> 2;
        end
        return h;
    endfunction

    // software visible state
    logic       idle_en_r;
    logic [2:0] internal_freq_select_r;
    logic [1:0] scs_r;
    logic       lfss_r;
    logic       mult_en_r;
    logic [5:0] tune_r;
    logic [3:0] fosc_r;
    logic [3:0] feat_r;
    logic       sec_en_r;
    logic       pri_ready_r;
    logic       secondary_run_mode_r;

    // oscillator state
    logic signed [5:0] tune_eff_r;
    logic [23:0]       step_cnt_r;
    logic [5:0]        slow_tune_r;
    logic              slow_pend_r;
    logic [2:0]        slow_edge_r;
    logic [15:0]       fast_cnt_r;
    logic              fast_clk_r;
    logic [15:0]       slow_cnt_r;
    logic              slow_clk_r;
    logic [4:0]        sync1_r;
    logic [4:0]        sync2_r;
    logic [3:0]        src_prev_r;
    clk_src_e          sel_r;
    logic              dev_prev_r;
    logic              quarter_r;
    logic              fosc4_r;
    pwr_state_e        st_nxt;
    logic [15:0]       wake_cnt_r;
    logic [15:0]       wake_len_r;

    logic        mult_avail;
    logic        tune_wr;
    clk_src_e    tgt;
    logic [3:0]  src_lvl;
    logic [15:0] fast_reload;
    logic [15:0] slow_reload;

    // multiplier only for internal primary at 4 or 8 MHz
    assign mult_avail  = fosc_internal(fosc_r) && (internal_freq_select_r[2:1] == 2'b11); // RQ12
    assign tune_wr     = reg_wr && (reg_addr == `ADDR_OSC_TUNING);
    assign fast_reload = fast_half(internal_freq_select_r, mult_active_r,
                                   FAST_BASE + {{10{tune_eff_r[5]}}, tune_eff_r}) - 16'h0001;
    assign slow_reload = SLOW_BASE + {{10{slow_tune_r[5]}}, slow_tune_r} - 16'h0001; // RQ7
    assign src_lvl     = {sync2_r[`SYN_SEC], sync2_r[`SYN_PRI], slow_clk_r, fast_clk_r};

    // target source from clock select, primary config and frequency select
    always_comb begin
        if (scs_r == 2'b01) begin
            tgt = SRC_SEC;
        end else if (scs_r == 2'b00 && !fosc_internal(fosc_r)) begin
            tgt = SRC_PRI;
        end else if (internal_freq_select_r == 3'h0 && !lfss_r) begin
            tgt = SRC_SLOW; // RQ10 RQ4
        end else begin
            tgt = SRC_FAST; // RQ4
        end
    end

    // control register fields
    always_ff @(posedge clk) begin
        if (rst) begin
            idle_en_r <= 1'b0;
            internal_freq_select_r    <= `RST_INTERNAL_FREQ_SELECT;
            scs_r     <= 2'b00;
        end else if (reg_wr && reg_addr == `ADDR_OSC_CONTROL) begin
            idle_en_r <= reg_wdata[`CTL_IDLE_BIT];
            internal_freq_select_r    <= reg_wdata[6:4];
            scs_r     <= reg_wdata[1:0];
        end
    end

    // tuning, configuration and aux fields
    always_ff @(posedge clk) begin
        if (rst) begin
            lfss_r   <= 1'b0;
            tune_r   <= 6'h00;
            fosc_r   <= `RST_FOSC;
            feat_r   <= 4'h0;
            sec_en_r <= 1'b0;
        end else begin
            if (tune_wr) begin
                lfss_r <= reg_wdata[`TUN_LFSS_BIT];
                tune_r <= reg_wdata[5:0];
            end
            if (reg_wr && reg_addr == `ADDR_OSC_CONFIG) begin
                fosc_r <= reg_wdata[3:0];
                feat_r <= reg_wdata[7:4];
            end
            if (reg_wr && reg_addr == `ADDR_OSC_AUX) begin
                sec_en_r <= reg_wdata[`AUX_SECEN_BIT];
            end
        end
    end

    // enable is forced low while the multiplier is unavailable
    always_ff @(posedge clk) begin
        if (rst || !mult_avail) begin
            mult_en_r <= 1'b0; // RQ13
        end else if (tune_wr) begin
            mult_en_r <= reg_wdata[`TUN_MULT_BIT]; // RQ11
        end
    end

    // register read, data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst || !reg_rd) begin
            reg_rdata_r <= 8'h00;
        end else begin
            unique case (reg_addr)
                `ADDR_OSC_CONTROL: reg_rdata_r <= {idle_en_r, internal_freq_select_r, pri_ready_r, 1'b0, scs_r};
                `ADDR_OSC_TUNING:  reg_rdata_r <= {lfss_r, mult_en_r, tune_r};
                `ADDR_OSC_CONFIG:  reg_rdata_r <= {feat_r, fosc_r};
                `ADDR_OSC_AUX:     reg_rdata_r <= {2'b00, pwr_state_r, 1'b0,
                                                   sync2_r[`SYN_SEC_START], secondary_run_mode_r, sec_en_r};
            endcase
        end
    end

    // fast tuning slews one step at a time; no done flag by design
    always_ff @(posedge clk) begin
        if (rst) begin
            tune_eff_r <= 6'sh00;
            step_cnt_r <= 24'h000000;
        end else if (tune_eff_r == $signed(tune_r)) begin
            step_cnt_r <= 24'h000000; // RQ9
        end else if (step_cnt_r == STEP_LAST) begin
            step_cnt_r <= 24'h000000;
            tune_eff_r <= (tune_eff_r < $signed(tune_r)) ? tune_eff_r + 6'sh01
                                                          : tune_eff_r - 6'sh01; // RQ8
        end else begin
            step_cnt_r <= step_cnt_r + 24'h000001;
        end
    end

    // slow clock picks up the new trim after eight of its own edges
    always_ff @(posedge clk) begin
        if (rst) begin
            slow_tune_r <= 6'h00;
            slow_pend_r <= 1'b0;
            slow_edge_r <= 3'h0;
        end else if (tune_wr) begin
            slow_pend_r <= 1'b1;
            slow_edge_r <= 3'h0;
        end else if (slow_pend_r && slow_cnt_r == 16'h0000 && !slow_clk_r) begin
            slow_edge_r <= slow_edge_r + 3'h1;
            if (slow_edge_r == `SLOW_TUNE_EDGES) begin
                slow_tune_r <= tune_r; // RQ8
                slow_pend_r <= 1'b0;
            end
        end
    end

    // oscillator run enables; a selected source never stops under the mux
    always_ff @(posedge clk) begin
        if (rst) begin
            fast_osc_on_r <= 1'b0;
            slow_rc_on_r  <= 1'b0;
            mult_active_r <= 1'b0;
        end else begin
            fast_osc_on_r <= (tgt == SRC_FAST) || (sel_r == SRC_FAST); // RQ2
            slow_rc_on_r  <= (tgt == SRC_SLOW) || (sel_r == SRC_SLOW) || (feat_r != 4'h0); // RQ3
            mult_active_r <= mult_en_r && mult_avail; // RQ11 RQ12
        end
    end

    // fast divider reloads only at a toggle, so no half period is cut short
    always_ff @(posedge clk) begin
        if (rst || !fast_osc_on_r) begin
            fast_cnt_r <= 16'h0000;
            fast_clk_r <= 1'b0;
        end else if (fast_cnt_r == 16'h0000) begin
            fast_clk_r <= ~fast_clk_r; // RQ1
            fast_cnt_r <= fast_reload; // RQ22
        end else begin
            fast_cnt_r <= fast_cnt_r - 16'h0001;
        end
    end

    // slow rc divider, separate from the fast path
    always_ff @(posedge clk) begin
        if (rst || !slow_rc_on_r) begin
            slow_cnt_r <= 16'h0000;
            slow_clk_r <= 1'b0;
        end else if (slow_cnt_r == 16'h0000) begin
            slow_clk_r <= ~slow_clk_r; // RQ7
            slow_cnt_r <= slow_reload;
        end else begin
            slow_cnt_r <= slow_cnt_r - 16'h0001;
        end
    end

    // two-stage synchronisers for everything arriving on pins
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else begin
            sync1_r <= {osc_pin_two_in, osc_pin_one_in, sec_osc_started, sec_osc_in, pri_osc_in};
            sync2_r <= sync1_r;
        end
    end

    // switch only while output is low and the new source has just fallen
    always_ff @(posedge clk) begin
        if (rst) begin
            src_prev_r <= 4'h0;
            sel_r      <= SRC_FAST;
            dev_clk_r  <= 1'b0;
        end else begin
            src_prev_r <= src_lvl;
            if (tgt != sel_r && !dev_clk_r && src_prev_r[tgt] && !src_lvl[tgt]) begin
                sel_r     <= tgt; // RQ22
                dev_clk_r <= 1'b0;
            end else begin
                dev_clk_r <= src_lvl[sel_r];
            end
        end
    end

    // status flags follow the source actually driving the device clock
    always_ff @(posedge clk) begin
        if (rst) begin
            pri_ready_r  <= 1'b0;
            secondary_run_mode_r    <= 1'b0;
            pri_osc_en_r <= 1'b1;
        end else begin
            pri_ready_r  <= (scs_r == 2'b00) && (sel_r == tgt) && (sel_r != SRC_SEC); // RQ15 RQ18
            secondary_run_mode_r    <= (sel_r == SRC_SEC); // RQ18
            pri_osc_en_r <= (sel_r != SRC_SEC); // RQ18
        end
    end

    // device clock over four for the clock-out pin
    always_ff @(posedge clk) begin
        if (rst) begin
            dev_prev_r <= 1'b0;
            quarter_r  <= 1'b0;
            fosc4_r    <= 1'b0;
        end else begin
            dev_prev_r <= dev_clk_r;
            if (dev_clk_r && !dev_prev_r) begin
                quarter_r <= ~quarter_r;
                if (quarter_r) begin
                    fosc4_r <= ~fosc4_r;
                end
            end
        end
    end

    // oscillator pin reuse; external oscillator modes leave both pins undriven
    always_ff @(posedge clk) begin
        if (rst) begin
            osc_pin_one_out_r     <= 1'b0;
            osc_pin_one_oe_r      <= 1'b0;
            osc_pin_two_out_r     <= 1'b0;
            osc_pin_two_oe_r      <= 1'b0;
            port_a_bit_seven_in_r <= 1'b0;
            port_a_bit_six_in_r   <= 1'b0;
        end else begin
            port_a_bit_seven_in_r <= sync2_r[`SYN_PIN1];
            port_a_bit_six_in_r   <= sync2_r[`SYN_PIN2];
            osc_pin_one_out_r     <= port_a_bit_seven_out;
            osc_pin_one_oe_r      <= fosc_internal(fosc_r) && port_a_bit_seven_oe; // RQ5 RQ6
            if (fosc_r == `FOSC_CLKOUT) begin
                osc_pin_two_out_r <= fosc4_r; // RQ5
                osc_pin_two_oe_r  <= 1'b1;
            end else if (fosc_r == `FOSC_ALL_IO) begin
                osc_pin_two_out_r <= port_a_bit_six_out; // RQ6
                osc_pin_two_oe_r  <= port_a_bit_six_oe;
            end else begin
                osc_pin_two_out_r <= 1'b0;
                osc_pin_two_oe_r  <= 1'b0;
            end
        end
    end

    // power state next value; sleep for secondary idle needs the enable
    always_comb begin
        st_nxt = pwr_state_r;
        unique case (pwr_state_r)
            ST_RUN: begin
                if (sleep_instr && !(scs_r == 2'b01 && !sec_en_r)) begin // RQ20
                    st_nxt = idle_en_r ? ST_IDLE : ST_SLEEP; // RQ14 RQ17
                end
            end
            ST_IDLE, ST_SLEEP: begin
                if (wake_event) begin
                    st_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (wake_cnt_r == WAKE_LAST) begin
                    st_nxt = ST_RUN; // RQ16 RQ19
                end
            end
        endcase
    end

    // power state and clock gates; wake settle counted before cpu resumes
    always_ff @(posedge clk) begin
        if (rst) begin
            pwr_state_r     <= ST_RUN;
            wake_cnt_r      <= 16'h0000;
            cpu_clk_on_r    <= 1'b1;
            periph_clk_on_r <= 1'b1;
        end else begin
            pwr_state_r     <= st_nxt;
            wake_cnt_r      <= (pwr_state_r == ST_WAKE) ? wake_cnt_r + 16'h0001 : 16'h0000;
            cpu_clk_on_r    <= (st_nxt == ST_RUN); // RQ15
            periph_clk_on_r <= (st_nxt != ST_SLEEP)
                               && !(sel_r == SRC_SEC && !sync2_r[`SYN_SEC_START]); // RQ21
        end
    end

    // helper: running count of the current wake settle, cleared to zero outside wake
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_len_r <= 16'h0000;
        end else begin
            wake_len_r <= (pwr_state_r == ST_WAKE) ? wake_len_r + 16'h0001 : 16'h0000;
        end
    end

    a_mult_forced: assert property (@(posedge clk) disable iff (rst) // RQ13
        !mult_avail |=> !mult_en_r) else $error("multiplier enable not forced low");

    a_mult_gate: assert property (@(posedge clk) disable iff (rst) // RQ12
        mult_active_r |-> $past(mult_avail) && $past(mult_en_r))
        else $error("multiplier active outside its modes");

    a_fast_runs: assert property (@(posedge clk) disable iff (rst) // RQ2
        !$past(rst) && (tgt == SRC_FAST) |=> fast_osc_on_r)
        else $error("fast oscillator off while needed");

    a_slow_auto: assert property (@(posedge clk) disable iff (rst) // RQ3
        (feat_r != 4'h0) |=> slow_rc_on_r) else $error("slow rc off with feature enabled");

    a_sleep_ignored: assert property (@(posedge clk) disable iff (rst) // RQ20
        (pwr_state_r == ST_RUN && sleep_instr && scs_r == 2'b01 && !sec_en_r)
        |=> pwr_state_r == ST_RUN && cpu_clk_on_r) else $error("sleep not ignored");

    a_wake_settle: assert property (@(posedge clk) disable iff (rst) // RQ16 RQ19
        ($past(pwr_state_r) == ST_WAKE && pwr_state_r == ST_RUN)
        |-> wake_len_r == 16'(WAKE_CYC) && cpu_clk_on_r) else $error("wake settle length wrong");

    a_cpu_gated: assert property (@(posedge clk) disable iff (rst) // RQ15
        (pwr_state_r == ST_IDLE) |-> !cpu_clk_on_r ##1 (pwr_state_r != ST_RUN))
        else $error("cpu clocked in idle");

    a_sec_flags: assert property (@(posedge clk) disable iff (rst) // RQ18
        (sel_r == SRC_SEC) |=> secondary_run_mode_r && !pri_ready_r && !pri_osc_en_r)
        else $error("secondary switch flags wrong");

    a_switch_clean: assert property (@(posedge clk) disable iff (rst) // RQ22
        $changed(sel_r) |-> !$past(dev_clk_r) && !dev_clk_r) else $error("clock switch glitch");

    a_periph_hold: assert property (@(posedge clk) disable iff (rst) // RQ21
        (sel_r == SRC_SEC && !sync2_r[`SYN_SEC_START]) |=> !periph_clk_on_r)
        else $error("peripherals clocked before secondary start");

    a_tune_step: assert property (@(posedge clk) disable iff (rst) // RQ8
        $changed(tune_eff_r) |-> (step_cnt_r == 24'h000000) && $past(step_cnt_r) == STEP_LAST)
        else $error("tuning stepped off schedule");

    a_clkout_pin: assert property (@(posedge clk) disable iff (rst) // RQ5
        (fosc_r == `FOSC_CLKOUT) |=> osc_pin_two_oe_r && osc_pin_two_out_r == $past(fosc4_r))
        else $error("clock-out pin not driven");

endmodule // internal_osc_and_idle_clock_ctrl

/* tb/tb_internal_osc_and_idle_clock_ctrl.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; \
    $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module tb_internal_osc_and_idle_clock_ctrl;
    import clock_ctrl_pkg::*;
    logic       clk, rst, reg_wr, reg_rd, sleep_instr, wake_event;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_r, rd_v;
    logic       pri_osc_in, sec_osc_in, sec_osc_started, osc_pin_one_in, osc_pin_two_in;
    logic       p7_out, p7_oe, p6_out, p6_oe, pin1_o, pin1_oe, pin2_o, pin2_oe, p7_in, p6_in;
    logic       dev_clk, cpu_on, per_on, fast_on, slow_on, pri_en, mult_on;
    pwr_state_e pwr;
    int         failures = 0, checks = 0, cyc = 0, i, n, t0;
    // sim counts are shortened so slow and tuning paths finish quickly
    internal_osc_and_idle_clock_ctrl #(.FAST_HALF_CYC(40), .SLOW_HALF_CYC(2000),
        .TUNE_SETTLE_CYC(640)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .sleep_instr(sleep_instr), .wake_event(wake_event), .pri_osc_in(pri_osc_in),
        .sec_osc_in(sec_osc_in), .sec_osc_started(sec_osc_started),
        .osc_pin_one_in(osc_pin_one_in), .osc_pin_one_out_r(pin1_o),
        .osc_pin_one_oe_r(pin1_oe), .osc_pin_two_in(osc_pin_two_in),
        .osc_pin_two_out_r(pin2_o), .osc_pin_two_oe_r(pin2_oe),
        .port_a_bit_seven_out(p7_out), .port_a_bit_seven_oe(p7_oe),
        .port_a_bit_seven_in_r(p7_in), .port_a_bit_six_out(p6_out),
        .port_a_bit_six_oe(p6_oe), .port_a_bit_six_in_r(p6_in), .dev_clk_r(dev_clk),
        .cpu_clk_on_r(cpu_on), .periph_clk_on_r(per_on), .fast_osc_on_r(fast_on),
        .slow_rc_on_r(slow_on), .pri_osc_en_r(pri_en), .mult_active_r(mult_on),
        .pwr_state_r(pwr));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // secondary oscillator stand-in, slow square wave
    always begin
        repeat (20) @(posedge clk);
        sec_osc_in <= ~sec_osc_in;
    end
    // hang guard, well above the total test length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata_r;
    endtask
    task automatic pulse_sleep_then_wake(input logic per_exp);
        @(posedge clk) sleep_instr <= 1'b1;
        @(posedge clk) sleep_instr <= 1'b0;
        #1 `CHK("cpu off", 1'b0, cpu_on)
        `CHK("per idle", per_exp, per_on)
        @(posedge clk) wake_event <= 1'b1;
        @(posedge clk) wake_event <= 1'b0;
        #1 `CHK("wake st", ST_WAKE, pwr)
        repeat (19) @(posedge clk);
        #1 `CHK("cpu held", 1'b0, cpu_on)
        @(posedge clk);
        #1 `CHK("cpu back", 1'b1, cpu_on)
    endtask
    task automatic t_reset();
        rd(2'h1); `CHK("tune rst", 8'h00, rd_v)
        rd(2'h2); `CHK("cfg rst", 8'h08, rd_v)
        for (i = 0; i < 1500 && DUT.reg_rdata_r !== 8'h48; i++) rd(2'h0);
        `CHK("ctrl rst", 8'h48, rd_v)
        `CHK("fast on", 1'b1, fast_on)
        `CHK("slow off", 1'b0, slow_on)
        wr(2'h1, 8'h80); wr(2'h0, 8'h00); repeat (2) @(posedge clk);
        #1 `CHK("lf fast", 1'b0, slow_on)
        wr(2'h1, 8'h00); repeat (2) @(posedge clk);
        #1 `CHK("lf slow", 1'b1, slow_on)
        wr(2'h0, 8'h40);
        $display("done reset");
    endtask
    task automatic t_pins();
        @(posedge clk);
        p7_out <= 1'b1; p7_oe <= 1'b1; p6_out <= 1'b0; p6_oe <= 1'b1; osc_pin_one_in <= 1'b1;
        osc_pin_two_in <= 1'b1;
        repeat (5) @(posedge clk);
        #1 `CHK("pin1 drv", 2'b11, {pin1_o, pin1_oe})
        `CHK("pin2 drv", 2'b01, {pin2_o, pin2_oe})
        `CHK("bit7 in", 1'b1, p7_in)
        `CHK("bit6 in", 1'b1, p6_in)
        wr(2'h0, 8'h70); wr(2'h2, 8'h09);
        n = 0;
        t0 = 0;
        for (i = 0; i < 700; i++) begin
            @(posedge clk);
            #1 if (i > 0 && pin2_o !== rd_v[0]) begin
                n++;
                if (n == 2) `CHK("pin2 half", 4 * 40, i - t0)
                t0 = i;
            end
            rd_v[0] = pin2_o;
        end
        `CHK("pin2 oe", 1'b1, pin2_oe)
        `CHK("pin2 tgl", 1'b1, n >= 2 && n <= 4)
        `CHK("pin1 bit7", 2'b11, {pin1_o, pin1_oe})
        $display("done pins");
    endtask
    task automatic t_mult();
        wr(2'h0, 8'h40); wr(2'h1, 8'h40); rd(2'h1);
        `CHK("mult lock", 8'h00, rd_v)
        wr(2'h0, 8'h70); wr(2'h1, 8'h40); rd(2'h1);
        `CHK("mult en", 8'h40, rd_v)
        repeat (4) @(posedge clk);
        #1 `CHK("mult act", 1'b1, mult_on)
        repeat (50) @(posedge clk);
        #1 rd_v[0] = dev_clk;
        n = 0;
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            #1 if (dev_clk && !rd_v[0]) n++;
            rd_v[0] = dev_clk;
        end
        `CHK("mult rate", 10, n)
        wr(2'h2, 8'h02); repeat (4) @(posedge clk);
        #1 `CHK("mult off", 1'b0, mult_on)
        wr(2'h2, 8'h18); repeat (4) @(posedge clk);
        #1 `CHK("rc auto", 1'b1, slow_on)
        $display("done mult");
    endtask
    task automatic t_primary_idle_mode();
        wr(2'h0, 8'hE0);
        for (i = 0; i < 1500 && DUT.reg_rdata_r !== 8'hE8; i++) rd(2'h0);
        pulse_sleep_then_wake(1'b1);
        rd(2'h0); `CHK("ctrl kept", 8'hE8, rd_v)
        wr(2'h0, 8'h60);
        pulse_sleep_then_wake(1'b0);
        $display("done primary_idle_mode");
    endtask
    task automatic t_sec();
        wr(2'h3, 8'h00); wr(2'h0, 8'hF1);
        @(posedge clk) sleep_instr <= 1'b1;
        @(posedge clk) sleep_instr <= 1'b0;
        #1 `CHK("sleep ign", ST_RUN, pwr)
        wr(2'h3, 8'h01);
        // the switch waits for a falling secondary edge while the device clock is low
        for (i = 0; i < 300 && pri_en !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1 `CHK("per held", 1'b0, per_on)
        @(posedge clk) sec_osc_started <= 1'b1;
        for (i = 0; i < 30 && DUT.reg_rdata_r[1] !== 1'b1; i++) rd(2'h3);
        `CHK("secondary_run_mode", 1'b1, rd_v[1])
        `CHK("pri off", 1'b0, pri_en)
        rd(2'h0); `CHK("rdy clr", 8'hF1, rd_v)
        pulse_sleep_then_wake(1'b1);
        #1 `CHK("per kept", 1'b1, per_on)
        $display("done secondary_idle_mode");
    endtask
    initial begin
        rst = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0; sleep_instr = 0;
        wake_event = 0; pri_osc_in = 0; sec_osc_in = 0; sec_osc_started = 0;
        osc_pin_one_in = 0; osc_pin_two_in = 0; p7_out = 0; p7_oe = 0; p6_out = 0; p6_oe = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pins();
        t_mult();
        wr(2'h2, 8'h08);
        t_primary_idle_mode();
        t_sec();
        give_verdict();
    end
endmodule // tb_internal_osc_and_idle_clock_ctrl
